//--- hdl/pcs_sense.sv
/*
 * Digital side of the shunt current sensor: encodes each sampled
 * input as an active-low PWM low time, two channels per sync period,
 * plus a debounced, latched overcurrent flag.
 * Assumes vin_mv is a signed millivolt sample on clk; the sync and
 * pin read-backs are asynchronous and are synchronised here.
 */
// Notes on behaviour
// - PWM result pin is open collector, only ever pulled low.
// - Duty limited to 10..30 percent; zero input gives 20 percent.
// - Duty is 20 percent minus 40 percent per volt of input.
// - Sync high interval is channel one, sync low interval channel two.
// - Each interval is encoded from its own period, independent of sync duty.
// - Output reaches the new duty within 0.51 to 1.3 sync periods.
// - Measure delay runs from sync edge to PWM pin rising edge.
// - Overcurrent flag is open drain, low while the fault is latched.
// - Overcurrent when absolute input exceeds the threshold.
// - Flag latches only after the condition lasts the debounce time.
// - Latch clears when PWM pin is held low for the clear time.
// - While flagged, the PWM pin is released high.
// - Cleared while still overcurrent, the flag returns at next sync edge.
`timescale 1ns/10ps
`include "pcs_params.svh"

module pcs_sense
	import pcs_pkg::*;
#(
	parameter logic [`PCS_VIN_W-1:0] OC_THR_MV = 12'h190
) (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  sync_in,
	input  wire logic [`PCS_VIN_W-1:0] vin_mv,
	input  wire logic                  pwm_result_in,
	output pcs_od_s                    pwm_result_out_n,
	output pcs_od_s                    overcurrent_flag_n,
	output logic                       chan_r,
	output logic [`PCS_DUTY_W-1:0]     duty_pm_r
);

	localparam int DEB_CYC = `PCS_DEBOUNCE_CYC;
	localparam int CLR_CYC = `PCS_CLEAR_CYC;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic sync_s1_r, sync_s2_r, sync_s3_r;
	logic pin_s1_r, pin_s2_r;
	logic sync_edge;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_s1_r <= 1'b0;
			sync_s2_r <= 1'b0;
			sync_s3_r <= 1'b0;
			pin_s1_r  <= 1'b1;
			pin_s2_r  <= 1'b1;
		end else begin
			sync_s1_r <= sync_in;
			sync_s2_r <= sync_s1_r;
			sync_s3_r <= sync_s2_r;
			pin_s1_r  <= pwm_result_in;
			pin_s2_r  <= pin_s1_r;
		end
	end

	assign sync_edge = sync_s2_r ^ sync_s3_r;

	// ************************************************************
	// Duty computation
	// ************************************************************
	logic signed [`PCS_VIN_W-1:0] vin_s;
	logic signed [15:0]           duty_raw;
	logic [`PCS_DUTY_W-1:0]       duty_nxt;
	logic [`PCS_CNT_W-1:0]        per_nxt;
	logic [`PCS_CNT_W+`PCS_DUTY_W-1:0] prod;
	logic [`PCS_CNT_W-1:0]        low_len_nxt;

	assign vin_s = $signed(vin_mv);

	always_comb begin
		// 40 %/V is 0.4 per mille per mV
		duty_raw = 16'(`PCS_DUTY_ZERO_PM)
			- 16'(($signed(16'(vin_s)) * 16'sd4) / 16'sd10);
		if (duty_raw < 16'sd100)
			duty_nxt = `PCS_DUTY_W'(`PCS_DUTY_MIN_PM);
		else if (duty_raw > 16'sd300)
			duty_nxt = `PCS_DUTY_W'(`PCS_DUTY_MAX_PM);
		else
			duty_nxt = duty_raw[`PCS_DUTY_W-1:0];
	end

	// ************************************************************
	// Interval timing
	// ************************************************************
	pcs_cnt_t cnt_r, per_r, low_len_r, low_cnt_r;
	logic     valid_r;

	assign per_nxt = cnt_r + `PCS_CNT_W'(1);
	// low time scaled by the interval just ended
	assign prod = per_nxt * duty_nxt;
	assign low_len_nxt = `PCS_CNT_W'(prod / `PCS_PM_SCALE);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cnt_r <= '0;
		else if (sync_edge)
			cnt_r <= '0;
		else if (cnt_r != '1)
			cnt_r <= cnt_r + `PCS_CNT_W'(1);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			per_r     <= '0;
			low_len_r <= '0;
			duty_pm_r <= `PCS_DUTY_W'(`PCS_DUTY_ZERO_PM);
			chan_r    <= 1'b0;
			valid_r   <= 1'b0;
		end else if (sync_edge) begin
			per_r     <= per_nxt;
			low_len_r <= low_len_nxt;
			duty_pm_r <= duty_nxt;
			// Tag the interval just ended: its level is the old one
			chan_r    <= sync_s3_r;
			valid_r   <= 1'b1;
		end
	end

	// low phase opens on the edge, rises after low_len
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			low_cnt_r <= '1;
		else if (sync_edge)
			low_cnt_r <= '0;
		else if (low_cnt_r != '1)
			low_cnt_r <= low_cnt_r + `PCS_CNT_W'(1);
	end

	// ************************************************************
	// Overcurrent
	// ************************************************************
	logic [`PCS_VIN_W-1:0] vin_abs;
	logic                  oc_cond;
	logic [7:0]            deb_cnt_r;
	logic [7:0]            clr_cnt_r;
	logic                  rearm_r;
	pcs_fault_e            fault_r;
	logic                  deb_done, clr_done, set_req;

	assign vin_abs  = vin_s[`PCS_VIN_W-1] ? -vin_mv : vin_mv;
	assign oc_cond  = vin_abs > OC_THR_MV;
	assign deb_done = deb_cnt_r >= 8'(DEB_CYC);
	assign clr_done = clr_cnt_r >= 8'(CLR_CYC);
	// after a clear, wait for the next sync edge
	assign set_req  = deb_done && (!rearm_r || sync_edge);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			deb_cnt_r <= '0;
		else if (!oc_cond)
			deb_cnt_r <= '0;
		else if (!deb_done)
			deb_cnt_r <= deb_cnt_r + 8'h01;
	end

	// count cycles the pin is held low from outside
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			clr_cnt_r <= '0;
		else if (fault_r != PCS_FAULT_LATCHED || pin_s2_r)
			clr_cnt_r <= '0;
		else if (!clr_done)
			clr_cnt_r <= clr_cnt_r + 8'h01;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rearm_r <= 1'b0;
		else if (fault_r == PCS_FAULT_LATCHED && clr_done)
			rearm_r <= 1'b1;
		else if (sync_edge || !oc_cond)
			rearm_r <= 1'b0;
	end

	// Set on a sync edge wins over clear; otherwise a live fault drops until the next edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			fault_r <= PCS_FAULT_CLEAR;
		else begin
			case (fault_r)
				PCS_FAULT_CLEAR: begin
					if (set_req)
						fault_r <= PCS_FAULT_LATCHED;
				end
				PCS_FAULT_LATCHED: begin
					if (clr_done && !(deb_done && sync_edge))
						fault_r <= PCS_FAULT_CLEAR;
				end
				default: fault_r <= PCS_FAULT_CLEAR;
			endcase
		end
	end

	// ************************************************************
	// Pin drive
	// ************************************************************
	// pull low only in the low phase and never while flagged
	assign pwm_result_out_n.o  = 1'b0;
	assign pwm_result_out_n.oe = valid_r && fault_r == PCS_FAULT_CLEAR
		&& low_cnt_r < low_len_r;
	assign overcurrent_flag_n.o  = 1'b0;
	assign overcurrent_flag_n.oe = fault_r == PCS_FAULT_LATCHED;

	// ************************************************************
	// Checks
	// ************************************************************
	chk_zero_duty: assert property (@(posedge clk) disable iff (!nrst)
		sync_edge && vin_mv == '0 |=> duty_pm_r == 9'h0C8)
		else $error("zero input not encoded as 20 percent");
	chk_duty_span: assert property (@(posedge clk) disable iff (!nrst)
		duty_pm_r >= 9'h064 && duty_pm_r <= 9'h12C)
		else $error("duty outside 10..30 percent");
	chk_duty_gain: assert property (@(posedge clk) disable iff (!nrst)
		sync_edge && vin_mv == 12'h064 |=> duty_pm_r == 9'h0A0)
		else $error("duty gain wrong at 100 mV");
	chk_chan_tag: assert property (@(posedge clk) disable iff (!nrst)
		sync_edge |=> chan_r == $past(sync_s3_r))
		else $error("channel tag does not follow sync level");
	chk_period_own: assert property (@(posedge clk) disable iff (!nrst)
		sync_edge |=> per_r == $past(cnt_r) + 16'h0001)
		else $error("period not taken from the ended interval");
	chk_low_start: assert property (@(posedge clk) disable iff (!nrst)
		sync_edge && valid_r && fault_r == PCS_FAULT_CLEAR
		&& !set_req && low_len_nxt != '0 |=> pwm_result_out_n.oe)
		else $error("low phase did not open after sync edge");
	chk_flag_release: assert property (@(posedge clk) disable iff (!nrst)
		overcurrent_flag_n.oe |-> !pwm_result_out_n.oe)
		else $error("pwm pulled low while flagged");
	chk_debounce_len: assert property (@(posedge clk) disable iff (!nrst)
		$rose(overcurrent_flag_n.oe) |-> $past(oc_cond, 1)
		&& $past(oc_cond, 8) && $past(deb_cnt_r) == 8'h46)
		else $error("flag set before debounce time");
	chk_clear_hold: assert property (@(posedge clk) disable iff (!nrst)
		$fell(overcurrent_flag_n.oe) |-> $past(!pin_s2_r, 1)
		&& $past(!pin_s2_r, 8) && $past(clr_cnt_r) == 8'h0A)
		else $error("flag cleared without clear pulse");
	chk_rearm_edge: assert property (@(posedge clk) disable iff (!nrst)
		$rose(overcurrent_flag_n.oe) && $past(rearm_r) |-> $past(sync_edge))
		else $error("flag re-asserted off a sync edge");

endmodule

//--- include/pcs_params.svh
/*
 * Timing counts, duty encoding and widths for the current-sense
 * PWM readout.
 * Assumes a 20 MHz core clock; every count below is derived from it.
 */
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// ************************************************************
// Clock
// ************************************************************
`define PCS_CLK_KHZ         20000

// ************************************************************
// Fault timing, times in ns
// ************************************************************
`define PCS_DEBOUNCE_NS     3500
`define PCS_DEBOUNCE_CYC    ((`PCS_DEBOUNCE_NS * `PCS_CLK_KHZ + 999999) / 1000000)
`define PCS_CLEAR_NS        500
`define PCS_CLEAR_CYC       ((`PCS_CLEAR_NS * `PCS_CLK_KHZ) / 1000000)

// ************************************************************
// Duty encoding, per mille; gain in percent per volt
// ************************************************************
`define PCS_DUTY_ZERO_PM    200
`define PCS_DUTY_MIN_PM     100
`define PCS_DUTY_MAX_PM     300
`define PCS_GAIN_PCT_PER_V  40
`define PCS_PM_SCALE        1000

// ************************************************************
// Widths
// ************************************************************
`define PCS_VIN_W           12
`define PCS_CNT_W           16
`define PCS_DUTY_W          9

`endif

//--- include/pcs_pkg.sv
/*
 * Types shared by the current-sense PWM readout.
 * Assumes pcs_params.svh is on the include path.
 */
`include "pcs_params.svh"

package pcs_pkg;

	// Open-drain pin drive: oe high pulls the pin to the low level
	typedef struct packed {
		logic o;
		logic oe;
	} pcs_od_s;

	typedef enum logic {
		PCS_FAULT_CLEAR,
		PCS_FAULT_LATCHED
	} pcs_fault_e;

	typedef logic [`PCS_CNT_W-1:0] pcs_cnt_t;

endpackage

//--- tb/pcs_ctrl_model.sv
/*
 * Controller-side model: makes the sync, drives the clear pulse and
 * resolves both open-drain wires with their pull-ups.
 * Assumes the open-drain structs of pcs_pkg and one clock.
 */
`timescale 1ns/10ps

module pcs_ctrl_model
	import pcs_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     tie,
	input  wire logic     clr,
	input  wire pcs_cnt_t hi_len,
	input  wire pcs_cnt_t lo_len,
	input  pcs_od_s       pwm_od,
	input  pcs_od_s       flag_od,
	output logic          sync_o,
	output logic          pwm_wire,
	output logic          flag_wire
);
	pcs_cnt_t cnt_r  = '0;
	logic     sync_r = 1'b0;

	always @(posedge clk) begin
		if (cnt_r + 16'h0001 >= (sync_r ? hi_len : lo_len)) begin
			cnt_r  <= '0;
			sync_r <= ~sync_r;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
	assign sync_o = sync_r;

	// gain straps are analog only; nothing to drive here
	assign pwm_wire  = (pwm_od.oe ? pwm_od.o : 1'b1) & ~clr &
		(tie & flag_od.oe ? flag_od.o : 1'b1);
	assign flag_wire = (flag_od.oe ? flag_od.o : 1'b1) &
		~(tie & (pwm_od.oe | clr));
endmodule

//--- tb/test_pcs_sense.sv
/*
 * Self-checking bench for the current-sense PWM readout.
 * Assumes the controller model beside it and a 20 MHz clock.
 */
`timescale 1ns/10ps
`include "pcs_params.svh"

module test_pcs_sense;
	import pcs_pkg::*;
	logic                   clk, nrst, tie, clr, sync, pwm_w, flag_w, chan;
	logic [`PCS_VIN_W-1:0]  vin;
	logic [`PCS_DUTY_W-1:0] duty;
	pcs_cnt_t               hi, lo;
	pcs_od_s                pwm_od, flag_od;
	int                     error_cnt, checks, cyc;

	pcs_sense u_dut (.clk(clk), .nrst(nrst), .sync_in(sync), .vin_mv(vin),
		.pwm_result_in(pwm_w), .pwm_result_out_n(pwm_od),
		.overcurrent_flag_n(flag_od), .chan_r(chan), .duty_pm_r(duty));
	pcs_ctrl_model u_ctrl (.clk(clk), .tie(tie), .clr(clr), .hi_len(hi),
		.lo_len(lo), .pwm_od(pwm_od), .flag_od(flag_od), .sync_o(sync),
		.pwm_wire(pwm_w), .flag_wire(flag_w));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string m);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Low length of the next pulse on the wire, sampled mid-cycle
	task automatic pulse_len(output int len);
		int w;
		len = 0;
		w = 0;
		while (pwm_w !== 1'b0 && w < 400) begin
			@(negedge clk);
			w++;
		end
		while (pwm_w === 1'b0 && len < 400) begin
			@(negedge clk);
			len++;
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_duty;
		logic [11:0] tv [6] = '{12'h000, 12'h064, 12'hF9C, 12'h0FA,
			12'hF06, 12'h177};
		int v, d, len;
		for (int i = 0; i < 6; i++) begin
			vin <= tv[i];
			v = $signed(tv[i]);
			d = 200 - v * 4 / 10;
			d = d < 100 ? 100 : (d > 300 ? 300 : d);
			@(sync);
			pulse_len(len);
			chk(duty, d[15:0], "duty code");
			chk(len[15:0], d[15:0] / 10, "low length");
			chk(pwm_od.o, 0, "pwm level");
		end
		$display("test duty done");
	endtask

	task automatic t_chan;
		int len;
		hi <= 16'h003C;
		lo <= 16'h008C;
		vin <= '0;
		repeat (3) @(sync);
		repeat (2) begin
			@(sync);
			pulse_len(len);
			chk(chan, !sync, "channel tag");
			chk(len[15:0], sync ? 28 : 12, "uneven sync");
		end
		hi <= 16'h0064;
		lo <= 16'h0064;
		repeat (3) @(sync);
		$display("test chan done");
	endtask

	task automatic t_fault;
		int lows;
		vin <= 12'h1F4;
		cycles(60);
		vin <= '0;
		cycles(2);
		vin <= 12'h1F4;
		cycles(60);
		chk(flag_od.oe, 0, "debounce restart");
		cycles(20);
		chk(flag_w, 0, "flag latched");
		vin <= '0;
		lows = 0;
		repeat (250) begin
			@(negedge clk);
			lows += !pwm_w;
		end
		chk(lows[15:0], 0, "pwm off in fault");
		cycles(1);
		clr <= 1'b1;
		cycles(14);
		clr <= 1'b0;
		cycles(3);
		chk(flag_od.oe, 0, "clear by pulse");
		@(sync);
		pulse_len(lows);
		chk(lows[15:0], 20, "resume after clear");
		$display("test fault done");
	endtask

	task automatic t_reassert;
		vin <= 12'hE0C;
		cycles(80);
		@(sync);
		cycles(5);
		clr <= 1'b1;
		cycles(14);
		clr <= 1'b0;
		cycles(3);
		chk(flag_od.oe, 0, "cleared in fault");
		@(sync);
		cycles(4);
		chk(flag_od.oe, 1, "set at sync edge");
		vin <= '0;
		tie <= 1'b1;
		cycles(20);
		chk(flag_od.oe, 0, "auto clear");
		vin <= 12'h1F4;
		cycles(76);
		chk(flag_w, 0, "tied flag low");
		vin <= '0;
		cycles(20);
		chk(flag_od.oe, 0, "tied flag clear");
		tie <= 1'b0;
		$display("test reassert done");
	endtask

	// ************************************************************
	// Run
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			error_cnt++;
			results();
		end
	end

	initial begin
		nrst = 1'b0;
		tie = 1'b0;
		clr = 1'b0;
		vin = '0;
		hi = 16'h0064;
		lo = 16'h0064;
		cycles(20);
		nrst <= 1'b1;
		repeat (3) @(sync);
		t_duty();
		t_chan();
		t_fault();
		t_reassert();
		results();
	end
endmodule
